// >>> rtl/ocpi_freq_div.sv
`timescale 1ns/100ps
`default_nettype none
module ocpi_freq_div (
  input wire logic sys_clk,
  input wire logic rst_n,
  ocpi_freq_if.div_side fi
);

  // Oscillator tap chosen by the select code and both pick bits
  function automatic ocpi_pkg::ocpi_src_t src_of(
    input logic [2:0] sel, input logic low, input logic mid);
    ocpi_pkg::ocpi_src_t s;
    s = ocpi_pkg::SRC_FAST;
    if (sel == ocpi_pkg::FREQ_LOWEST && !low) begin
      s = ocpi_pkg::SRC_SLOW;
    end else if (sel < ocpi_pkg::FREQ_DIV16 && mid) begin
      s = ocpi_pkg::SRC_MID;
    end
    return s;
  endfunction : src_of

  // Power-of-two divide applied to the chosen tap
  function automatic logic [3:0] shift_of(
    input logic [2:0] sel, input logic low, input logic mid);
    logic [3:0] sh;
    sh = 4'h0;
    if (sel >= ocpi_pkg::FREQ_DIV16) begin
      sh = 4'(ocpi_pkg::FREQ_DIV1 - sel);
    end else if (mid) begin
      case (sel)
        ocpi_pkg::FREQ_250K: sh = 4'h1;
        ocpi_pkg::FREQ_LOWEST: sh = low ? ocpi_pkg::SHIFT_MID_LOW : 4'h0;
        default: sh = 4'h0;
      endcase
    end else begin
      case (sel)
        ocpi_pkg::FREQ_500K: sh = ocpi_pkg::SHIFT_FAST_500K;
        ocpi_pkg::FREQ_250K: sh = ocpi_pkg::SHIFT_FAST_250K;
        default: sh = low ? ocpi_pkg::SHIFT_FAST_LOW : 4'h0;
      endcase
    end
    return sh;
  endfunction : shift_of

  logic [8:0] fast_cnt_ff;
  logic [3:0] mid_cnt_ff;
  logic int_tick_ff;
  ocpi_pkg::ocpi_src_t src;
  logic [3:0] shift;
  logic [8:0] mask;
  logic nxt_tick;

  // Decode follows the select bits with no extra trigger
  always_comb begin
    src = src_of(fi.freq_sel, fi.low_pick, fi.mid_sel);
    shift = shift_of(fi.freq_sel, fi.low_pick, fi.mid_sel);
    mask = 9'((10'h001 << shift) - 10'h001);
    case (src)
      ocpi_pkg::SRC_FAST:
        nxt_tick = fi.fast_tick && (fast_cnt_ff & mask) == 9'h000;
      ocpi_pkg::SRC_MID:
        nxt_tick = fi.mid_tick && (mid_cnt_ff & mask[3:0]) == 4'h0;
      ocpi_pkg::SRC_SLOW: nxt_tick = fi.slow_tick;
      default: nxt_tick = 1'b0;
    endcase
  end

  // Free-running prescalers on the fast and mid taps
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_cnt_ff <= 9'h000;
      mid_cnt_ff <= 4'h0;
    end else begin
      if (fi.fast_tick) fast_cnt_ff <= fast_cnt_ff + 9'h001;
      if (fi.mid_tick) mid_cnt_ff <= mid_cnt_ff + 4'h1;
    end
  end

  // Registered internal clock enable
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) int_tick_ff <= 1'b0;
    else int_tick_ff <= nxt_tick;
  end
  assign fi.int_tick = int_tick_ff;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_high_divide: assert property (
    fi.freq_sel >= 3'h3 |-> src == ocpi_pkg::SRC_FAST
      && shift == 4'(3'h7 - fi.freq_sel))
    else $error("high range divide wrong");
  a_fast_low_pick: assert property (
    (!fi.mid_sel && fi.freq_sel < 3'h3) |->
      ((fi.freq_sel == 3'h0 && !fi.low_pick)
        ? src == ocpi_pkg::SRC_SLOW
        : (src == ocpi_pkg::SRC_FAST && shift == (fi.freq_sel == 3'h2
          ? 4'h5 : fi.freq_sel == 3'h1 ? 4'h6 : 4'h9))))
    else $error("low range fast tap wrong");
  a_div512_low: assert property (
    (fi.low_pick && !fi.mid_sel && fi.freq_sel == 3'h0) |->
      src == ocpi_pkg::SRC_FAST && mask == 9'h1FF)
    else $error("divide by 512 not chosen");
  a_mid_tap: assert property (
    (fi.mid_sel && fi.freq_sel inside {3'h1, 3'h2}) |->
      src == ocpi_pkg::SRC_MID && shift == 4'(3'h2 - fi.freq_sel))
    else $error("mid tap divide wrong");

endmodule : ocpi_freq_div
`default_nettype wire

// >>> rtl/ocpi_freq_if.sv
`timescale 1ns/100ps
`default_nettype none
interface ocpi_freq_if;
  logic [2:0] freq_sel;
  logic low_pick;
  logic mid_sel;
  logic fast_tick;
  logic mid_tick;
  logic slow_tick;
  logic int_tick;

  modport ctl (
    output freq_sel, low_pick, mid_sel, fast_tick, mid_tick, slow_tick,
    input int_tick
  );
  modport div_side (
    input freq_sel, low_pick, mid_sel, fast_tick, mid_tick, slow_tick,
    output int_tick
  );
endinterface : ocpi_freq_if
`default_nettype wire

// >>> rtl/ocpi_pkg.sv
package ocpi_pkg;

  // Register bus geometry
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 2;

  // Register offsets
  localparam logic [1:0] OFF_OSC_CONTROL = 2'h0;
  localparam logic [1:0] OFF_OSC_TUNE = 2'h1;
  localparam logic [1:0] OFF_OSC_CONTROL_TWO = 2'h2;
  localparam logic [1:0] OFF_POWER_STATUS = 2'h3;

  // Field positions in osc_control_reg
  localparam int unsigned BIT_IDLE_ON_SLEEP = 7;
  localparam int unsigned FREQ_LSB = 4;
  localparam int unsigned BIT_STARTUP_DONE = 3;
  localparam int unsigned BIT_HF_STABLE = 2;
  localparam int unsigned CLK_SEL_LSB = 0;

  // Field positions in osc_tune_reg and osc_control_reg_two
  localparam int unsigned BIT_LOW_PICK = 7;
  localparam int unsigned BIT_PLL_ON = 6;
  localparam int unsigned TUNE_LSB = 0;
  localparam int unsigned TUNE_W = 6;
  localparam int unsigned BIT_MID_SEL = 0;

  // Field positions in the power status register
  localparam int unsigned STATE_LSB = 4;
  localparam int unsigned ACT_SRC_LSB = 0;

  // Reset values
  localparam logic RST_IDLE_ON_SLEEP = 1'b0;
  localparam logic [2:0] RST_FREQ_SEL = 3'h6;
  localparam logic [1:0] RST_CLK_SEL = 2'h0;
  localparam logic [7:0] RST_OSC_TUNE = 8'h00;
  localparam logic RST_MID_SEL = 1'b0;

  // Clock source select codes and active source codes
  localparam logic [1:0] CLK_SEL_PRIMARY = 2'h0;
  localparam logic [1:0] CLK_SEL_SECONDARY = 2'h1;
  localparam logic [1:0] ACT_PRIMARY = 2'h0;
  localparam logic [1:0] ACT_SECONDARY = 2'h1;
  localparam logic [1:0] ACT_INTERNAL = 2'h2;

  // Internal frequency select codes
  localparam logic [2:0] FREQ_DIV1 = 3'h7;
  localparam logic [2:0] FREQ_DIV16 = 3'h3;
  localparam logic [2:0] FREQ_500K = 3'h2;
  localparam logic [2:0] FREQ_250K = 3'h1;
  localparam logic [2:0] FREQ_LOWEST = 3'h0;
  localparam logic [3:0] SHIFT_FAST_500K = 4'h5;
  localparam logic [3:0] SHIFT_FAST_250K = 4'h6;
  localparam logic [3:0] SHIFT_FAST_LOW = 4'h9;
  localparam logic [3:0] SHIFT_MID_LOW = 4'h4;

  // Timing
  localparam int unsigned SYS_CLK_HZ = 20_000_000;
  localparam int unsigned SYS_CLK_PERIOD_NS = 1_000_000_000 / SYS_CLK_HZ;
  localparam int unsigned WAKE_READY_DELAY_NS = 200;
  localparam int unsigned WAKE_READY_CYCLES =
    (WAKE_READY_DELAY_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS < 1 ? 1 :
    (WAKE_READY_DELAY_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int unsigned WAKE_CNT_W = 8;
  localparam int unsigned STARTUP_TIMER_TICKS = 1024;
  localparam int unsigned STARTUP_CNT_W = 11;

  // Power mode states
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_IDLE = 4'h2,
    ST_SLEEP = 4'h4,
    ST_WAKE = 4'h8
  } ocpi_state_t;

  // Internal oscillator taps
  typedef enum logic [2:0] {
    SRC_FAST = 3'h1,
    SRC_MID = 3'h2,
    SRC_SLOW = 3'h4
  } ocpi_src_t;

endpackage : ocpi_pkg

// >>> rtl/ocpi_top.sv
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module ocpi_top #(
  parameter int unsigned STARTUP_TICKS = ocpi_pkg::STARTUP_TIMER_TICKS
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [ocpi_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ocpi_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ocpi_pkg::DATA_W-1:0] reg_rdata,
  input wire logic sleep_exec,
  input wire logic wake_event,
  input wire logic two_speed_startup_cfg,
  input wire logic fast_osc_stable,
  input wire logic primary_tick,
  input wire logic secondary_tick,
  input wire logic fast_osc_tick,
  input wire logic mid_osc_tick,
  input wire logic slow_osc_tick,
  output logic primary_osc_en,
  output logic pll_on,
  output logic [ocpi_pkg::TUNE_W-1:0] osc_tune_trim,
  output logic [1:0] clk_src,
  output logic cpu_tick,
  output logic periph_tick,
  output logic cpu_halted
);

  ocpi_freq_if fi ();

  ocpi_pkg::ocpi_state_t state_ff;
  ocpi_pkg::ocpi_state_t nxt_state;
  logic idle_on_sleep_ff;
  logic [2:0] freq_sel_ff;
  logic [1:0] clk_sel_ff;
  logic [7:0] tune_ff;
  logic mid_sel_ff;
  logic done_ff;
  logic strap_taken_ff;
  logic hf_stable_ff;
  logic [ocpi_pkg::STARTUP_CNT_W-1:0] st_cnt_ff;
  logic [ocpi_pkg::WAKE_CNT_W-1:0] wake_cnt_ff;
  logic [7:0] rdata_ff;
  logic [1:0] clk_src_ff;
  logic cpu_tick_ff;
  logic periph_tick_ff;
  logic [1:0] act_src;
  logic src_tick;
  logic wr_ctl;
  logic wr_clk_sel_sec;
  logic timer_set;
  logic [7:0] ctl_view;

  assign wr_ctl = reg_wr && reg_addr == ocpi_pkg::OFF_OSC_CONTROL;
  assign wr_clk_sel_sec = wr_ctl &&
    reg_wdata[ocpi_pkg::CLK_SEL_LSB +: 2] == ocpi_pkg::CLK_SEL_SECONDARY;

  // Control register fields written by software
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_on_sleep_ff <= ocpi_pkg::RST_IDLE_ON_SLEEP;
      freq_sel_ff <= ocpi_pkg::RST_FREQ_SEL;
      clk_sel_ff <= ocpi_pkg::RST_CLK_SEL;
    end else if (wr_ctl) begin
      idle_on_sleep_ff <= reg_wdata[ocpi_pkg::BIT_IDLE_ON_SLEEP];
      freq_sel_ff <= reg_wdata[ocpi_pkg::FREQ_LSB +: 3];
      clk_sel_ff <= reg_wdata[ocpi_pkg::CLK_SEL_LSB +: 2];
    end
  end

  // Tune register and second control register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tune_ff <= ocpi_pkg::RST_OSC_TUNE;
      mid_sel_ff <= ocpi_pkg::RST_MID_SEL;
    end else begin
      if (reg_wr && reg_addr == ocpi_pkg::OFF_OSC_TUNE) begin
        tune_ff <= reg_wdata;
      end
      if (reg_wr && reg_addr == ocpi_pkg::OFF_OSC_CONTROL_TWO) begin
        mid_sel_ff <= reg_wdata[ocpi_pkg::BIT_MID_SEL];
      end
    end
  end

  assign pll_on = tune_ff[ocpi_pkg::BIT_PLL_ON];
  assign osc_tune_trim = tune_ff[ocpi_pkg::TUNE_LSB +: ocpi_pkg::TUNE_W];

  // Internal oscillator divider hookup
  assign fi.freq_sel = freq_sel_ff;
  assign fi.low_pick = tune_ff[ocpi_pkg::BIT_LOW_PICK];
  assign fi.mid_sel = mid_sel_ff;
  assign fi.fast_tick = fast_osc_tick;
  assign fi.mid_tick = mid_osc_tick;
  assign fi.slow_tick = slow_osc_tick;

  ocpi_freq_div u_freq_div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .fi(fi)
  );

  // Primary stops whenever the secondary is selected
  assign primary_osc_en = clk_sel_ff != ocpi_pkg::CLK_SEL_SECONDARY;

  // Startup timer counts primary periods once the strap is taken
  assign timer_set = primary_osc_en && strap_taken_ff && !done_ff
    && primary_tick
    && st_cnt_ff == ocpi_pkg::STARTUP_CNT_W'(STARTUP_TICKS - 1);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_cnt_ff <= '0;
    end else if (!primary_osc_en || done_ff || wr_clk_sel_sec) begin
      st_cnt_ff <= '0;
    end else if (primary_tick && strap_taken_ff) begin
      st_cnt_ff <= st_cnt_ff + 1'b1;
    end
  end

  // Startup done: strap load, timer set wins over secondary clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_ff <= 1'b0;
      strap_taken_ff <= 1'b0;
    end else if (!strap_taken_ff) begin
      done_ff <= !two_speed_startup_cfg;
      strap_taken_ff <= 1'b1;
    end else if (timer_set) begin
      done_ff <= 1'b1;
    end else if (wr_clk_sel_sec) begin
      done_ff <= 1'b0;
    end
  end

  // Fast internal stable status, read only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) hf_stable_ff <= 1'b0;
    else hf_stable_ff <= fast_osc_stable;
  end

  // Source actually clocking the device
  always_comb begin
    if (clk_sel_ff == ocpi_pkg::CLK_SEL_SECONDARY) begin
      act_src = ocpi_pkg::ACT_SECONDARY;
    end else if (clk_sel_ff[1] || !done_ff) begin
      act_src = ocpi_pkg::ACT_INTERNAL;
    end else begin
      act_src = ocpi_pkg::ACT_PRIMARY;
    end
    case (act_src)
      ocpi_pkg::ACT_PRIMARY: src_tick = primary_tick;
      ocpi_pkg::ACT_SECONDARY: src_tick = secondary_tick;
      default: src_tick = fi.int_tick;
    endcase
  end

  // Power mode sequencing
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ocpi_pkg::ST_RUN: begin
        if (sleep_exec) begin
          nxt_state = idle_on_sleep_ff ? ocpi_pkg::ST_IDLE
                                       : ocpi_pkg::ST_SLEEP;
        end
      end
      ocpi_pkg::ST_IDLE: begin
        if (wake_event) nxt_state = ocpi_pkg::ST_WAKE;
      end
      ocpi_pkg::ST_SLEEP: begin
        if (wake_event) nxt_state = ocpi_pkg::ST_WAKE;
      end
      ocpi_pkg::ST_WAKE: begin
        if (wake_cnt_ff == '0) nxt_state = ocpi_pkg::ST_RUN;
      end
      default: nxt_state = ocpi_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) state_ff <= ocpi_pkg::ST_RUN;
    else state_ff <= nxt_state;
  end

  // Ready delay between wake event and first instruction
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_cnt_ff <= '0;
    end else if (state_ff != ocpi_pkg::ST_WAKE) begin
      wake_cnt_ff <=
        ocpi_pkg::WAKE_CNT_W'(ocpi_pkg::WAKE_READY_CYCLES - 1);
    end else if (wake_cnt_ff != '0) begin
      wake_cnt_ff <= wake_cnt_ff - 1'b1;
    end
  end

  // Core and peripheral clock enables
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_tick_ff <= 1'b0;
      periph_tick_ff <= 1'b0;
      clk_src_ff <= ocpi_pkg::ACT_INTERNAL;
    end else begin
      cpu_tick_ff <= state_ff == ocpi_pkg::ST_RUN && src_tick;
      periph_tick_ff <= state_ff != ocpi_pkg::ST_SLEEP && src_tick;
      clk_src_ff <= act_src;
    end
  end

  assign cpu_tick = cpu_tick_ff;
  assign periph_tick = periph_tick_ff;
  assign clk_src = clk_src_ff;
  assign cpu_halted = state_ff != ocpi_pkg::ST_RUN;

  // Read view of the control register
  always_comb begin
    ctl_view = 8'h00;
    ctl_view[ocpi_pkg::BIT_IDLE_ON_SLEEP] = idle_on_sleep_ff;
    ctl_view[ocpi_pkg::FREQ_LSB +: 3] = freq_sel_ff;
    ctl_view[ocpi_pkg::BIT_STARTUP_DONE] = done_ff;
    ctl_view[ocpi_pkg::BIT_HF_STABLE] = hf_stable_ff;
    ctl_view[ocpi_pkg::CLK_SEL_LSB +: 2] = clk_sel_ff;
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else if (!reg_rd) begin
      rdata_ff <= 8'h00;
    end else begin
      case (reg_addr)
        ocpi_pkg::OFF_OSC_CONTROL: rdata_ff <= ctl_view;
        ocpi_pkg::OFF_OSC_TUNE: rdata_ff <= tune_ff;
        ocpi_pkg::OFF_OSC_CONTROL_TWO: rdata_ff <= {7'h00, mid_sel_ff};
        ocpi_pkg::OFF_POWER_STATUS:
          rdata_ff <= {state_ff, 2'h0, clk_src_ff};
        default: rdata_ff <= 8'h00;
      endcase
    end
  end
  assign reg_rdata = rdata_ff;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_sleep_to_idle: assert property (
    state_ff == ocpi_pkg::ST_RUN && sleep_exec && idle_on_sleep_ff
    |=> state_ff == ocpi_pkg::ST_IDLE)
    else $error("sleep with idle enable missed idle");
  a_sleep_full: assert property (
    state_ff == ocpi_pkg::ST_RUN && sleep_exec && !idle_on_sleep_ff
    |=> state_ff == ocpi_pkg::ST_SLEEP)
    else $error("sleep without idle enable missed sleep");
  a_strap_load: assert property (
    !strap_taken_ff |=> done_ff == !$past(two_speed_startup_cfg))
    else $error("startup done not loaded from strap");
  a_src_switch: assert property (
    wr_ctl |=> clk_sel_ff == $past(reg_wdata[1:0]) ##1 clk_src_ff ==
      ($past(clk_sel_ff) == 2'h1 ? 2'h1
        : ($past(clk_sel_ff[1]) || !$past(done_ff)) ? 2'h2 : 2'h0))
    else $error("clock source did not follow write");
  a_sec_clears: assert property (
    wr_clk_sel_sec && !timer_set |=> !done_ff && !primary_osc_en)
    else $error("secondary select kept primary or done");
  a_idle_halt: assert property (
    state_ff == ocpi_pkg::ST_IDLE && $past(state_ff) == ocpi_pkg::ST_IDLE
    |-> !cpu_tick_ff && periph_tick_ff == $past(src_tick))
    else $error("idle clock gating wrong");
  a_wake_delay: assert property (
    state_ff == ocpi_pkg::ST_IDLE && wake_event
    |=> (state_ff == ocpi_pkg::ST_WAKE)[*4] ##1 state_ff == ocpi_pkg::ST_RUN)
    else $error("wake ready delay wrong");
  a_wake_keeps: assert property (
    state_ff == ocpi_pkg::ST_IDLE && wake_event && !reg_wr && done_ff
    |=> done_ff && $stable(idle_on_sleep_ff) && $stable(clk_sel_ff))
    else $error("wake altered control bits");
  a_done_timer: assert property (
    timer_set |=> done_ff)
    else $error("timer expiry did not set done");

endmodule : ocpi_top
`default_nettype wire

// >>> verification/test_osc_control_primary_idle.sv
`timescale 1ns/100ps
`default_nettype none
module test_osc_control_primary_idle;
  typedef struct {
    logic [2:0] code;
    logic low;
    logic mid;
    logic [6:0] tl;
    int cnt;
  } ocpi_row_t;

  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic sleep_exec = 1'b0, wake_event = 1'b0, cfg = 1'b1, fstab = 1'b0;
  logic primary_tick = 1'b0, secondary_tick = 1'b0, fast_osc_tick = 1'b0;
  logic mid_osc_tick = 1'b0, slow_osc_tick = 1'b0, prim_on = 1'b0;
  logic [7:0] reg_rdata;
  logic primary_osc_en, pll_on, cpu_tick, periph_tick, cpu_halted;
  logic [5:0] osc_tune_trim;
  logic [1:0] clk_src;
  logic [7:0] d;
  int cyc = 0;
  int n_errors = 0;
  int n_compared = 0;
  int c_cpu, c_per, i;

  // Counts in a 960-cycle window: fast every cycle, mid /3, slow /5
  ocpi_row_t rows[13] = '{
    '{3'h7, 1'b0, 1'b0, 7'h45, 960}, '{3'h6, 1'b0, 1'b0, 7'h00, 480},
    '{3'h5, 1'b0, 1'b0, 7'h3F, 240}, '{3'h4, 1'b0, 1'b0, 7'h40, 120},
    '{3'h3, 1'b0, 1'b0, 7'h2A, 60}, '{3'h2, 1'b0, 1'b0, 7'h15, 30},
    '{3'h1, 1'b0, 1'b0, 7'h01, 15}, '{3'h0, 1'b0, 1'b0, 7'h7F, 192},
    '{3'h0, 1'b1, 1'b0, 7'h00, 2}, '{3'h2, 1'b0, 1'b1, 7'h00, 320},
    '{3'h1, 1'b0, 1'b1, 7'h00, 160}, '{3'h0, 1'b0, 1'b1, 7'h00, 192},
    '{3'h0, 1'b1, 1'b1, 7'h00, 20}
  };

  // Clock, 50 ns period
  always #25 sys_clk = ~sys_clk;

  // Oscillator tick patterns
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    fast_osc_tick <= 1'b1;
    mid_osc_tick <= (cyc % 3 == 0);
    slow_osc_tick <= (cyc % 5 == 0);
    secondary_tick <= (cyc % 7 == 0);
    primary_tick <= prim_on & cyc[0];
  end

  ocpi_top #(.STARTUP_TICKS(8)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sleep_exec(sleep_exec),
    .wake_event(wake_event), .two_speed_startup_cfg(cfg),
    .fast_osc_stable(fstab), .primary_tick(primary_tick),
    .secondary_tick(secondary_tick), .fast_osc_tick(fast_osc_tick),
    .mid_osc_tick(mid_osc_tick), .slow_osc_tick(slow_osc_tick),
    .primary_osc_en(primary_osc_en), .pll_on(pll_on),
    .osc_tune_trim(osc_tune_trim), .clk_src(clk_src),
    .cpu_tick(cpu_tick), .periph_tick(periph_tick),
    .cpu_halted(cpu_halted)
  );

  task automatic tally_and_finish();
    if (n_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read strobe, data taken in the following cycle
  task automatic rd(input logic [1:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic count(input int n);
    c_cpu = 0;
    c_per = 0;
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      c_cpu += cpu_tick;
      c_per += periph_tick;
    end
  endtask : count

  task automatic wait_src(input logic [1:0] s);
    for (i = 0; i < 400 && clk_src !== s; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (clk_src !== s) begin
      n_errors++;
      tally_and_finish();
    end
  endtask : wait_src

  // One-cycle pulse on sleep or wake, then for a wake count edges until run
  task automatic pulse(input logic is_wake);
    @(posedge sys_clk);
    if (is_wake) wake_event <= 1'b1;
    else sleep_exec <= 1'b1;
    @(posedge sys_clk);
    wake_event <= 1'b0;
    sleep_exec <= 1'b0;
    #1;
    for (i = 0; is_wake && i < 20 && cpu_halted !== 1'b0; i++) begin
      @(posedge sys_clk);
      #1;
    end
  endtask : pulse

  // Hang guard
  initial begin
    repeat (90000) @(posedge sys_clk);
    n_errors++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    #1 chk({clk_src, primary_osc_en, pll_on, cpu_halted}, 5'b10100);
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(ocpi_pkg::OFF_OSC_CONTROL);
    chk(d, 8'h60);
    foreach (rows[k]) begin
      wr(ocpi_pkg::OFF_OSC_TUNE, {rows[k].low, rows[k].tl});
      wr(ocpi_pkg::OFF_OSC_CONTROL_TWO, {7'h7F, rows[k].mid});
      wr(ocpi_pkg::OFF_OSC_CONTROL, {1'b0, rows[k].code, 4'hC});
      rd(ocpi_pkg::OFF_OSC_CONTROL);
      chk(d, {1'b0, rows[k].code, 4'h0});
      rd(ocpi_pkg::OFF_OSC_TUNE);
      chk(d, {rows[k].low, rows[k].tl});
      chk({pll_on, osc_tune_trim}, rows[k].tl);
      rd(ocpi_pkg::OFF_OSC_CONTROL_TWO);
      chk(d[0], rows[k].mid);
      count(8);
      count(960);
      chk(c_cpu >= rows[k].cnt - 2 && c_cpu <= rows[k].cnt + 2, 1'b1);
    end
    // Status register ignores writes
    wr(ocpi_pkg::OFF_POWER_STATUS, 8'hFF);
    rd(ocpi_pkg::OFF_POWER_STATUS);
    chk({d[7:4], d[1:0]}, {4'h1, ocpi_pkg::ACT_INTERNAL});
    @(posedge sys_clk);
    fstab <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(ocpi_pkg::OFF_OSC_CONTROL);
    chk(d[2], 1'b1);
    // Primary start-up through the timer
    wr(ocpi_pkg::OFF_OSC_CONTROL, 8'h60);
    prim_on <= 1'b1;
    wait_src(ocpi_pkg::ACT_PRIMARY);
    rd(ocpi_pkg::OFF_OSC_CONTROL);
    chk(d[3], 1'b1);
    count(100);
    chk(c_cpu >= 48 && c_cpu <= 52, 1'b1);
    // Secondary source stops the primary
    wr(ocpi_pkg::OFF_OSC_CONTROL, 8'h61);
    wait_src(ocpi_pkg::ACT_SECONDARY);
    chk(primary_osc_en, 1'b0);
    rd(ocpi_pkg::OFF_OSC_CONTROL);
    chk(d[3], 1'b0);
    count(140);
    chk(c_cpu >= 18 && c_cpu <= 22, 1'b1);
    // Upper source codes run from the internal oscillator
    wr(ocpi_pkg::OFF_OSC_CONTROL, 8'h62);
    wait_src(ocpi_pkg::ACT_INTERNAL);
    chk(clk_src, ocpi_pkg::ACT_INTERNAL);
    // Software order for idle from another run mode
    wr(ocpi_pkg::OFF_OSC_CONTROL, 8'hE1);
    wr(ocpi_pkg::OFF_OSC_CONTROL, 8'hE0);
    wait_src(ocpi_pkg::ACT_PRIMARY);
    pulse(1'b0);
    chk(cpu_halted, 1'b1);
    count(100);
    chk({c_cpu == 0, c_per >= 48 && c_per <= 52}, 2'b11);
    rd(ocpi_pkg::OFF_OSC_CONTROL);
    chk(d, 8'hEC);
    rd(ocpi_pkg::OFF_POWER_STATUS);
    chk(d[7:4], 4'h2);
    pulse(1'b1);
    chk(16'(i), 16'(ocpi_pkg::WAKE_READY_CYCLES));
    count(40);
    chk({c_cpu >= 18 && c_cpu <= 22, clk_src}, 3'b100);
    rd(ocpi_pkg::OFF_OSC_CONTROL);
    chk(d, 8'hEC);
    // Full sleep stops both clocks
    wr(ocpi_pkg::OFF_OSC_CONTROL, 8'h60);
    pulse(1'b0);
    count(40);
    chk({c_cpu == 0, c_per == 0, cpu_halted}, 3'b111);
    rd(ocpi_pkg::OFF_POWER_STATUS);
    chk(d[7:4], 4'h4);
    pulse(1'b1);
    chk(cpu_halted, 1'b0);
    // Second reset with two-speed start-up off
    @(posedge sys_clk);
    rst_n <= 1'b0;
    cfg <= 1'b0;
    fstab <= 1'b0;
    prim_on <= 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(ocpi_pkg::OFF_OSC_CONTROL);
    chk(d, 8'h68);
    tally_and_finish();
  end
endmodule : test_osc_control_primary_idle
`default_nettype wire
